/* File: csd_pkg.sv */
// package of encodings, phases and reset values for the compare/skip/decrement/branch slice
//
// Summary of operation
// RL1: compare-skip-greater subtracts working register from file unsigned and skips when file is larger.
// RL2: compare-skip-greater is decoded from upper byte 0011 0010 with an 8-bit file address.
// RL3: compare-skip-less is decoded from 0011 0000 and skips when file is below working register, no flags.
// RL4: decimal adjust adds 6 to the low nibble when it exceeds 9 or digit carry is set.
// RL5: decimal adjust adds 6 to the high nibble when it exceeds 9 or carry is set; only carry changes.
// RL6: decimal adjust uses 0010 111s; s=0 writes file and working register, s=1 the file only.
// RL7: decrement uses 0000 011d, computes file minus one, updates overflow, carry, digit carry, zero.
// RL8: destination bit 0 writes the working register, 1 writes back the file register.
// RL9: decrement-skip-zero uses 0001 011d and leaves all flags unchanged.
// RL10: decrement-skip-zero skips the fetched next instruction when the result is zero.
// RL11: decrement-skip-nonzero uses 0010 011d, no flags, skips when the result is non-zero.
// RL12: in-page branch uses top bits 110 and loads a 13-bit literal into pc bits 12..0.
// RL13: after the branch the latch gets literal bits 12..8 in 4..0 and pc bits 15..13 in 7..5.
// RL14: the in-page branch always takes two cycles, the second doing nothing.
// RL15: increment uses 0001 010d, computes file plus one, updates overflow, carry, digit carry, zero.
// RL16: each cycle has decode, read, process and write phases; a skipped slot does nothing.
package csd_pkg;

  localparam logic [7:0] OP_CMP_GT   = 8'h32;
  localparam logic [7:0] OP_CMP_LT   = 8'h30;
  localparam logic [6:0] OP_DEC_ADJ  = 7'h17;
  localparam logic [6:0] OP_DEC      = 7'h03;
  localparam logic [6:0] OP_DEC_SZ   = 7'h0B;
  localparam logic [6:0] OP_DEC_SNZ  = 7'h13;
  localparam logic [6:0] OP_INC      = 7'h0A;
  localparam logic [2:0] OP_BRANCH   = 3'h6;
  localparam logic [3:0] BCD_LIMIT   = 4'h9;
  localparam logic [3:0] BCD_FIX     = 4'h6;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [1:0] PH_DECODE   = 2'h0;
  localparam logic [1:0] PH_READ     = 2'h1;
  localparam logic [1:0] PH_PROCESS  = 2'h2;
  localparam logic [1:0] PH_WRITE    = 2'h3;
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;

  typedef enum logic [1:0] {SLOT_EXEC, SLOT_SKIP, SLOT_BRIDLE} csd_slot_t;

  typedef enum logic [3:0] {
    K_NONE, K_CMPGT, K_CMPLT, K_DAW, K_DEC, K_DECSZ, K_DECSNZ, K_INC, K_BRANCH
  } csd_kind_t;

endpackage : csd_pkg

/* File: csd_alu.sv */
// arithmetic unit: increment, decrement, decimal adjust and compares
`timescale 1ns/10ps
module csd_alu
  import csd_pkg::*;
(
  input  csd_pkg::csd_kind_t kind,
  input  logic [7:0]         fileVal,
  input  logic [7:0]         working_register,
  input  logic [3:0]         flagsIn,
  output logic [7:0]         result,
  output logic [3:0]         flagsOut,
  output logic               skipCond
);
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic [3:0] lowN;
  logic [4:0] highN;

  always_comb begin
    sum      = 9'h000;
    lowSum   = 5'h00;
    lowN     = working_register[3:0];
    highN    = {1'b0, working_register[7:4]};
    result   = fileVal;
    flagsOut = flagsIn;
    skipCond = 1'b0;
    case (kind)
      // RL1 unsigned greater compare
      K_CMPGT: skipCond = fileVal > working_register;
      // RL3 unsigned less compare
      K_CMPLT: skipCond = fileVal < working_register;
      K_DAW: begin
        // RL4 low nibble adjust
        if (working_register[3:0] > BCD_LIMIT || flagsIn[FLAG_DC]) begin
          lowN = working_register[3:0] + BCD_FIX;
        end
        // RL5 high nibble adjust, carry only
        if (working_register[7:4] > BCD_LIMIT || flagsIn[FLAG_C]) begin
          highN = {1'b0, working_register[7:4]} + {1'b0, BCD_FIX};
        end
        result = {highN[3:0], lowN};
        flagsOut[FLAG_C] = highN[4] | flagsIn[FLAG_C];
      end
      K_INC, K_DEC: begin
        // RL15 increment flags
        if (kind == K_INC) begin
          sum    = {1'b0, fileVal} + 9'h001;
          lowSum = {1'b0, fileVal[3:0]} + 5'h01;
          flagsOut[FLAG_OV] = (fileVal == 8'h7F);
        end else begin
          // RL7 decrement as add of all ones
          sum    = {1'b0, fileVal} + 9'h0FF;
          lowSum = {1'b0, fileVal[3:0]} + 5'h0F;
          flagsOut[FLAG_OV] = (fileVal == 8'h80);
        end
        result = sum[7:0];
        flagsOut[FLAG_C]  = sum[8];
        flagsOut[FLAG_DC] = lowSum[4];
        flagsOut[FLAG_Z]  = (sum[7:0] == 8'h00);
      end
      K_DECSZ, K_DECSNZ: begin
        result = fileVal - 8'h01;
        // RL10 skip on zero
        // RL11 skip on non-zero
        skipCond = (kind == K_DECSZ) ? (result == 8'h00) : (result != 8'h00);
      end
      default: result = fileVal;
    endcase
  end
endmodule : csd_alu

/* File: csd_core.sv */
// execution core for compare, skip, decrement, decimal adjust and in-page branch
`timescale 1ns/10ps
module csd_core
  import csd_pkg::*;
(
  input  logic        sys_clk,
  input  logic        arst_n,
  input  logic [15:0] instrWord,
  input  logic [7:0]  fileRdData,
  output logic [7:0]  fileAddr,
  output logic        fileRdEn,
  output logic        fileWrEn,
  output logic [7:0]  fileWrData,
  output logic [7:0]  workingReg,
  output logic [15:0] progCounter,
  output logic [7:0]  pcHighLatch,
  output logic [3:0]  statusFlags,
  output logic [1:0]  phase,
  output logic        fetchAdvance,
  output logic        slotIdle
);
  import csd_pkg::*;

  // ****************************************
  // phase sequencer and instruction register
  // ****************************************
  logic [1:0]  phase_r, phase_nxt;
  csd_slot_t   slot_r, slot_nxt;
  logic [15:0] ir_r, ir_nxt;
  logic [7:0]  fileVal_r, fileVal_nxt;
  logic [7:0]  w_r, w_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0]  latch_r, latch_nxt;
  logic [3:0]  flags_r, flags_nxt;
  logic [7:0]  res_r, res_nxt;
  logic [3:0]  resFlags_r, resFlags_nxt;
  logic        skip_r, skip_nxt;
  logic        rdEn_r, rdEn_nxt;
  logic        wrEn_r, wrEn_nxt;
  logic [7:0]  wrData_r, wrData_nxt;
  logic        adv_r, adv_nxt;
  logic        idle_r, idle_nxt;

  csd_kind_t   kind;
  logic [7:0]  aluRes;
  logic [3:0]  aluFlags;
  logic        aluSkip;
  logic        dBit;

  function automatic csd_kind_t decode_kind(input logic [15:0] iw);
    csd_kind_t k;
    k = K_NONE;
    // RL2 greater compare pattern
    if (iw[15:8] == OP_CMP_GT) k = K_CMPGT;
    // RL3 less compare pattern
    else if (iw[15:8] == OP_CMP_LT) k = K_CMPLT;
    // RL6 decimal adjust pattern
    else if (iw[15:9] == OP_DEC_ADJ) k = K_DAW;
    // RL7 decrement pattern
    else if (iw[15:9] == OP_DEC) k = K_DEC;
    // RL9 skip-zero pattern
    else if (iw[15:9] == OP_DEC_SZ) k = K_DECSZ;
    // RL11 skip-nonzero pattern
    else if (iw[15:9] == OP_DEC_SNZ) k = K_DECSNZ;
    // RL15 increment pattern
    else if (iw[15:9] == OP_INC) k = K_INC;
    // RL12 branch pattern
    else if (iw[15:13] == OP_BRANCH) k = K_BRANCH;
    return k;
  endfunction : decode_kind

  assign kind = decode_kind(ir_r);
  assign dBit = ir_r[8];

  csd_alu u_alu (
    .kind     (kind),
    .fileVal  (fileVal_r),
    .working_register     (w_r),
    .flagsIn  (flags_r),
    .result   (aluRes),
    .flagsOut (aluFlags),
    .skipCond (aluSkip)
  );

  always_comb begin
    phase_nxt    = phase_r + 2'h1;
    slot_nxt     = slot_r;
    ir_nxt       = ir_r;
    fileVal_nxt  = fileVal_r;
    w_nxt        = w_r;
    pc_nxt       = pc_r;
    latch_nxt    = latch_r;
    flags_nxt    = flags_r;
    res_nxt      = res_r;
    resFlags_nxt = resFlags_r;
    skip_nxt     = skip_r;
    rdEn_nxt     = 1'b0;
    wrEn_nxt     = 1'b0;
    wrData_nxt   = wrData_r;
    adv_nxt      = 1'b0;
    idle_nxt     = (slot_r != SLOT_EXEC);
    // RL16 four phases per cycle
    case (phase_r)
      PH_DECODE: begin
        if (slot_r == SLOT_EXEC) begin
          ir_nxt = instrWord;
        end
      end
      PH_READ: begin
        if (slot_r == SLOT_EXEC && kind != K_BRANCH && kind != K_NONE) begin
          rdEn_nxt = 1'b1;
        end
        fileVal_nxt = fileRdData;
      end
      PH_PROCESS: begin
        if (slot_r == SLOT_EXEC) begin
          res_nxt      = aluRes;
          resFlags_nxt = aluFlags;
          skip_nxt     = aluSkip;
        end
      end
      PH_WRITE: begin
        adv_nxt  = 1'b1;
        slot_nxt = SLOT_EXEC;
        if (slot_r == SLOT_EXEC) begin
          case (kind)
            K_DAW: begin
              wrEn_nxt   = 1'b1;
              wrData_nxt = res_r;
              // RL6 s=0 also loads working register
              if (!dBit) w_nxt = res_r;
              flags_nxt = resFlags_r;
            end
            K_DEC, K_INC: begin
              // RL8 destination select
              if (dBit) begin
                wrEn_nxt   = 1'b1;
                wrData_nxt = res_r;
              end else begin
                w_nxt = res_r;
              end
              flags_nxt = resFlags_r;
            end
            K_DECSZ, K_DECSNZ: begin
              // RL8 destination select
              if (dBit) begin
                wrEn_nxt   = 1'b1;
                wrData_nxt = res_r;
              end else begin
                w_nxt = res_r;
              end
              // RL10 idle slot on skip
              if (skip_r) slot_nxt = SLOT_SKIP;
            end
            K_CMPGT, K_CMPLT: begin
              // RL1 idle slot on skip
              if (skip_r) slot_nxt = SLOT_SKIP;
            end
            K_BRANCH: begin
              // RL12 low 13 bits loaded
              pc_nxt = {pc_r[15:13], ir_r[12:0]};
              // RL13 latch update
              latch_nxt = {pc_r[15:13], ir_r[12:8]};
              // RL14 second cycle idle
              slot_nxt = SLOT_BRIDLE;
            end
            default: begin
            end
          endcase
          if (kind != K_BRANCH) pc_nxt = pc_r + 16'h0001;
        end else if (slot_r == SLOT_SKIP) begin
          // skipped slot: counter moves past the discarded word only
          pc_nxt = pc_r + 16'h0001;
        end
        // RL14 branch idle slot holds the target while it is fetched
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r    <= PH_DECODE;
      slot_r     <= SLOT_EXEC;
      ir_r       <= 16'h0000;
      fileVal_r  <= BYTE_RST;
      w_r        <= BYTE_RST;
      pc_r       <= PC_RST;
      latch_r    <= BYTE_RST;
      flags_r    <= 4'h0;
      res_r      <= BYTE_RST;
      resFlags_r <= 4'h0;
      skip_r     <= 1'b0;
      rdEn_r     <= 1'b0;
      wrEn_r     <= 1'b0;
      wrData_r   <= BYTE_RST;
      adv_r      <= 1'b0;
      idle_r     <= 1'b0;
    end else begin
      phase_r    <= phase_nxt;
      slot_r     <= slot_nxt;
      ir_r       <= ir_nxt;
      fileVal_r  <= fileVal_nxt;
      w_r        <= w_nxt;
      pc_r       <= pc_nxt;
      latch_r    <= latch_nxt;
      flags_r    <= flags_nxt;
      res_r      <= res_nxt;
      resFlags_r <= resFlags_nxt;
      skip_r     <= skip_nxt;
      rdEn_r     <= rdEn_nxt;
      wrEn_r     <= wrEn_nxt;
      wrData_r   <= wrData_nxt;
      adv_r      <= adv_nxt;
      idle_r     <= idle_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [7:0] addr_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= BYTE_RST;
    end else begin
      addr_r <= ir_nxt[7:0];
    end
  end

  assign fileAddr     = addr_r;
  assign fileRdEn     = rdEn_r;
  assign fileWrEn     = wrEn_r;
  assign fileWrData   = wrData_r;
  assign workingReg   = w_r;
  assign progCounter  = pc_r;
  assign pcHighLatch  = latch_r;
  assign statusFlags  = flags_r;
  assign phase        = phase_r;
  assign fetchAdvance = adv_r;
  assign slotIdle     = idle_r;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_branchWrite;
    phase_r == PH_WRITE && slot_r == SLOT_EXEC && kind == K_BRANCH;
  endsequence

  property p_branch_pc;
    @(posedge sys_clk) disable iff (!arst_n)
      s_branchWrite |=> pc_r == {$past(pc_r[15:13]), $past(ir_r[12:0])};
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch pc wrong"); // RL12

  property p_branch_latch;
    @(posedge sys_clk) disable iff (!arst_n)
      s_branchWrite |=> latch_r == {$past(pc_r[15:13]), $past(ir_r[12:8])};
  endproperty
  a_branch_latch: assert property (p_branch_latch) else $error("latch wrong"); // RL13

  property p_branch_idle;
    @(posedge sys_clk) disable iff (!arst_n)
      s_branchWrite |=> (slot_r == SLOT_BRIDLE && !wrEn_r && !rdEn_r)[*4];
  endproperty
  a_branch_idle: assert property (p_branch_idle) else $error("branch idle missing"); // RL14

  property p_bridle_pc;
    @(posedge sys_clk) disable iff (!arst_n)
      phase_r == PH_WRITE && slot_r == SLOT_BRIDLE |=> $stable(pc_r) && $stable(latch_r);
  endproperty
  a_bridle_pc: assert property (p_bridle_pc) else $error("idle slot moved pc"); // RL14

  property p_skip_silent;
    @(posedge sys_clk) disable iff (!arst_n)
      slot_r == SLOT_SKIP |-> !rdEn_nxt && !wrEn_nxt && flags_nxt == flags_r;
  endproperty
  a_skip_silent: assert property (p_skip_silent) else $error("skip slot active"); // RL16

  property p_gt_skip;
    @(posedge sys_clk) disable iff (!arst_n)
      phase_r == PH_PROCESS && slot_r == SLOT_EXEC && kind == K_CMPGT
      |-> ##1 (skip_r == ($past(fileVal_r) > $past(w_r))) ##1 (slot_r == SLOT_SKIP) == skip_r;
  endproperty
  a_gt_skip: assert property (p_gt_skip) else $error("greater skip wrong"); // RL1

  property p_lt_flags;
    @(posedge sys_clk) disable iff (!arst_n)
      phase_r == PH_WRITE && slot_r == SLOT_EXEC && (kind == K_CMPLT || kind == K_DECSZ
      || kind == K_DECSNZ) |=> $stable(flags_r);
  endproperty
  a_lt_flags: assert property (p_lt_flags) else $error("flags changed"); // RL3

  property p_dest_w;
    @(posedge sys_clk) disable iff (!arst_n)
      phase_r == PH_WRITE && slot_r == SLOT_EXEC && (kind == K_DEC || kind == K_INC) && !dBit
      |=> w_r == $past(res_r) && !wrEn_r;
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("destination wrong"); // RL8

  property p_dsz_skip;
    @(posedge sys_clk) disable iff (!arst_n)
      phase_r == PH_WRITE && slot_r == SLOT_EXEC && kind == K_DECSZ
      |=> (slot_r == SLOT_SKIP) == ($past(res_r) == 8'h00);
  endproperty
  a_dsz_skip: assert property (p_dsz_skip) else $error("zero skip wrong"); // RL10

  property p_daw_w;
    @(posedge sys_clk) disable iff (!arst_n)
      phase_r == PH_WRITE && slot_r == SLOT_EXEC && kind == K_DAW
      |=> wrEn_r && (w_r == ($past(dBit) ? $past(w_r) : wrData_r));
  endproperty
  a_daw_w: assert property (p_daw_w) else $error("decimal adjust dest"); // RL6

endmodule : csd_core

/* File: csd_core_bench.sv */
// self-checking bench for the compare, skip, decrement and in-page branch execution core
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin \
  checks_done++; \
  if ((gt) !== (ex)) begin \
    fail_count++; \
    $display("FAIL %s expected %0h seen %0h", nm, ex, gt); \
  end \
end
module csd_core_bench;
  import csd_pkg::*;

  typedef struct {
    logic [7:0]  working_register;
    logic [3:0]  flags;
    logic [15:0] pc;
    logic [7:0]  latch;
    logic        wrEn;
    logic [7:0]  wrData;
    logic [7:0]  addr;
    logic        rdEn;
    logic        idle;
  } csd_note_t;

  logic        sys_clk;
  logic        arst_n;
  logic [15:0] instrWord;
  logic [7:0]  fileRdData;
  logic [7:0]  fileAddr;
  logic        fileRdEn;
  logic        fileWrEn;
  logic [7:0]  fileWrData;
  logic [7:0]  workingReg;
  logic [15:0] progCounter;
  logic [7:0]  pcHighLatch;
  logic [3:0]  statusFlags;
  logic [1:0]  phase;
  logic        fetchAdvance;
  logic        slotIdle;
  csd_note_t   noteQ[$];
  csd_note_t   mdl;
  csd_note_t   expNote;
  int          fail_count;
  int          checks_done;
  integer      seed;
  logic        brIdle;
  logic        idleNext;
  int          i;
  logic [31:0] r;
  logic [7:0]  fv;
  logic [15:0] ins;

  csd_core uut (
    .sys_clk      (sys_clk),
    .arst_n       (arst_n),
    .instrWord    (instrWord),
    .fileRdData   (fileRdData),
    .fileAddr     (fileAddr),
    .fileRdEn     (fileRdEn),
    .fileWrEn     (fileWrEn),
    .fileWrData   (fileWrData),
    .workingReg   (workingReg),
    .progCounter  (progCounter),
    .pcHighLatch  (pcHighLatch),
    .statusFlags  (statusFlags),
    .phase        (phase),
    .fetchAdvance (fetchAdvance),
    .slotIdle     (slotIdle)
  );

  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  // ****************************************
  // reference model, one instruction slot
  // ****************************************
  task automatic run_slot(input logic [15:0] iw, input logic [7:0] fd);
    logic [7:0]  res;
    logic [3:0]  lo;
    logic [3:0]  hi;
    logic        skip;
    logic        cOut;
    logic [15:0] pcOld;
    begin
      instrWord  <= iw;
      fileRdData <= fd;
      pcOld      = mdl.pc;
      mdl.pc     = pcOld + 16'h0001;
      mdl.wrEn   = 1'b0;
      mdl.idle   = idleNext;
      // file read only in an executing slot of a file instruction
      mdl.rdEn   = !idleNext && (iw[15:8] inside {OP_CMP_GT, OP_CMP_LT}
                   || iw[15:9] inside {OP_DEC_ADJ, OP_DEC, OP_DEC_SZ, OP_DEC_SNZ, OP_INC});
      mdl.addr   = iw[7:0];
      skip       = 1'b0;
      cOut       = 1'b0;
      if (idleNext) begin
        // discarded word does nothing, branch idle keeps target
        if (brIdle) mdl.pc = pcOld;
        brIdle   = 1'b0;
        idleNext = 1'b0;
      end else if (iw[15:13] == OP_BRANCH) begin
        mdl.pc    = {pcOld[15:13], iw[12:0]};
        mdl.latch = {pcOld[15:13], iw[12:8]};
        brIdle    = 1'b1;
        skip      = 1'b1;
      end else if (iw[15:8] == OP_CMP_GT) begin
        skip = fd > mdl.working_register;
      end else if (iw[15:8] == OP_CMP_LT) begin
        skip = fd < mdl.working_register;
      end else if (iw[15:9] == OP_DEC_ADJ) begin
        lo = mdl.working_register[3:0];
        hi = mdl.working_register[7:4];
        if (lo > BCD_LIMIT || mdl.flags[FLAG_DC]) lo = lo + BCD_FIX;
        if (hi > BCD_LIMIT || mdl.flags[FLAG_C]) {cOut, hi} = {1'b0, hi} + {1'b0, BCD_FIX};
        res = {hi, lo};
        mdl.flags[FLAG_C] = mdl.flags[FLAG_C] | cOut;
        mdl.wrEn   = 1'b1;
        mdl.wrData = res;
        if (!iw[8]) mdl.working_register = res;
      end else if (iw[15:9] inside {OP_DEC, OP_DEC_SZ, OP_DEC_SNZ, OP_INC}) begin
        res = (iw[15:9] == OP_INC) ? fd + 8'h01 : fd - 8'h01;
        if (iw[15:9] == OP_INC) begin
          mdl.flags = {fd == 8'h7F, res == 8'h00, fd[3:0] == 4'hF, fd == 8'hFF};
        end else if (iw[15:9] == OP_DEC) begin
          mdl.flags = {fd == 8'h80, res == 8'h00, fd[3:0] != 4'h0, fd != 8'h00};
        end
        if (iw[15:9] == OP_DEC_SZ) skip = res == 8'h00;
        if (iw[15:9] == OP_DEC_SNZ) skip = res != 8'h00;
        if (iw[8]) begin
          mdl.wrEn   = 1'b1;
          mdl.wrData = res;
        end else begin
          mdl.working_register = res;
        end
      end
      idleNext = skip;
      noteQ.push_back(mdl);
      repeat (4) @(posedge sys_clk);
    end
  endtask : run_slot

  // ****************************************
  // result watcher
  // ****************************************
  always @(negedge sys_clk) begin
    if (fetchAdvance === 1'b1) begin
      if (noteQ.size() == 0) begin
        fail_count++;
        $display("FAIL fetchAdvance expected 0 seen 1");
      end else begin
        expNote = noteQ.pop_front();
        `CHK("phase", PH_DECODE, phase)
        `CHK("workingReg", expNote.working_register, workingReg)
        `CHK("statusFlags", expNote.flags, statusFlags)
        `CHK("fileWrEn", expNote.wrEn, fileWrEn)
        `CHK("pcHighLatch", expNote.latch, pcHighLatch)
        if (expNote.wrEn) begin
          `CHK("fileWrData", expNote.wrData, fileWrData)
          `CHK("fileAddr", expNote.addr, fileAddr)
        end
        `CHK("progCounter", expNote.pc, progCounter)
        `CHK("slotIdle", expNote.idle, slotIdle)
      end
    end
    if (phase === PH_PROCESS && noteQ.size() > 0) begin
      `CHK("fileRdEn", noteQ[0].rdEn, fileRdEn)
    end
  end

  task automatic give_verdict();
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask : give_verdict

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed        = 72995;
    fail_count  = 0;
    checks_done = 0;
    arst_n      = 1'b0;
    instrWord   = 16'h0000;
    fileRdData  = 8'h00;
    brIdle      = 1'b0;
    idleNext    = 1'b0;
    mdl = '{BYTE_RST, 4'h0, PC_RST, BYTE_RST, 1'b0, BYTE_RST, BYTE_RST, 1'b0, 1'b0};
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    // boundary file values mixed in, words in idle slots act as poison
    for (i = 0; i < 160; i++) begin
      r = $random(seed);
      case (r[2:0])
        3'h0: fv = 8'h00;
        3'h1: fv = 8'hFF;
        3'h2: fv = 8'h7F;
        3'h3: fv = 8'h80;
        3'h4: fv = mdl.working_register;
        default: fv = r[15:8];
      endcase
      case (r[18:16])
        3'h0: ins = {OP_CMP_GT, r[31:24]};
        3'h1: ins = {OP_CMP_LT, r[31:24]};
        3'h2: ins = {OP_DEC_ADJ, r[8], r[31:24]};
        3'h3: ins = {OP_DEC, r[8], r[31:24]};
        3'h4: ins = {OP_DEC_SZ, r[8], r[31:24]};
        3'h5: ins = {OP_DEC_SNZ, r[8], r[31:24]};
        3'h6: ins = {OP_INC, r[8], r[31:24]};
        default: ins = {8'h01, r[31:24]};
      endcase
      run_slot(ins, fv);
    end
    // third branch lands at the page end; its idle slot holds pc there, so the fourth still sees zero upper pc bits
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      run_slot({OP_BRANCH, (i == 2) ? 13'h1FFF : r[12:0]}, r[31:24]);
      run_slot({OP_INC, 1'b0, 8'h05}, 8'h41);
    end
    for (i = 0; i < 40 && noteQ.size() > 0; i++) @(posedge sys_clk);
    if (noteQ.size() > 0) begin
      fail_count++;
      $display("FAIL pending results expected 0 seen %0d", noteQ.size());
    end
    give_verdict();
  end

endmodule : csd_core_bench
